// *** pia_cfg.svh ***
// Register offsets, field positions and reset values of the PHY interrupt and aux status block.
`ifndef PIA_CFG_SVH
`define PIA_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets on the management register port
// ----------------------------------------------------------------------------
`define PIA_REG_MASK 5'h19
`define PIA_REG_STAT 5'h1a
`define PIA_REG_AUX 5'h1c

// ----------------------------------------------------------------------------
// Interrupt mask and pending flag fields
// ----------------------------------------------------------------------------
`define PIA_PIN_EN_BIT 15
`define PIA_SUM_BIT 15
`define PIA_EV_SPEED 14
`define PIA_EV_LINK 13
`define PIA_EV_DUPLEX 12
`define PIA_EV_DOWNSHIFT 2
`define PIA_EV_RXERR 0
`define PIA_RSVD_HI 7
`define PIA_RSVD_LO 4
`define PIA_MASK_WR 16'hff6f
`define PIA_EV_VALID 15'h7f6f
`define PIA_MASK_RST 16'h0000
`define PIA_FLAGS_RST 15'h0000

// ----------------------------------------------------------------------------
// Auxiliary status fields
// ----------------------------------------------------------------------------
`define PIA_AUX_ANC 15
`define PIA_AUX_AN_DIS 14
`define PIA_AUX_MDIX 13
`define PIA_AUX_CD_SWAP 12
`define PIA_AUX_POL_HI 11
`define PIA_AUX_POL_LO 8
`define PIA_AUX_TMO_MSB 7
`define PIA_AUX_TMO_LSB 2
`define PIA_TMO_RST 2'h1

`endif

// *** pia_pkg.sv ***
// Types shared by the PHY interrupt and aux status block.
package pia_pkg;

    // ------------------------------------------------------------------------
    // Status levels from the PHY core
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic an_complete;
        logic an_enable;
        logic mdix_crossover;
        logic cd_swap;
        logic [3:0] pol_inv;
        logic [3:0] adv_bits;
        logic carrier_ext;
    } pia_phy_stat_t;

    // ------------------------------------------------------------------------
    // Management register port request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        logic rd;
        logic wr;
        logic [15:0] wdata;
    } pia_mgmt_req_t;

    // ------------------------------------------------------------------------
    // Complete block state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] mask;
        logic [14:0] flags;
        logic [1:0] tmo;
        logic [15:0] rdata;
        logic pin_oe;
    } pia_state_t;

endpackage

// *** pia_irq_aux.sv ***
// PHY interrupt mask, clear-on-read pending flags and auxiliary status register.
//
// What this block does
// - Drive interrupt pin only when master enable set.
// - Enabled pin follows the pending summary bit.
// - Master enable clear never alters flag capture.
// - Mask bits enable same-position events; 7,4 zero.
// - Mask bits reset to zero and are sticky.
// - Status read returns flags then clears them.
// - Bit 15 summarises pending; low bits name causes.
// - Thirteen event sources at their fixed positions.
// - Speed and duplex events need autonegotiation enabled.
// - Downshift event needs advertisement bits all set.
// - No receive-error event during carrier extension.
// - Aux bit 15 copies autonegotiation complete.
// - Aux bit 14 is inverted autonegotiation enable.
// - Aux bit 13 shows internal crossover performed.
// - Aux bit 12 shows C/D pairs swapped.
// - Aux bits 11..8 show pair A..D polarity fixes.
// - Sticky two-bit link timeout, bits 7 and 2.
// - Sticky bits survive soft reset when enabled.
// - Timeout field resets to code 01.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"

module pia_irq_aux (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire pia_pkg::pia_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    input wire logic [14:0] event_pulse,
    input wire pia_pkg::pia_phy_stat_t phy_stat,
    input wire logic soft_reset,
    input wire logic sticky_reset_en,
    output logic management_interrupt_pin_o,
    output logic management_interrupt_pin_oe,
    output logic [1:0] link_tmo_code
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------------
    localparam pia_pkg::pia_state_t RST_ST = '{
        mask: `PIA_MASK_RST,
        flags: `PIA_FLAGS_RST,
        tmo: `PIA_TMO_RST,
        rdata: 16'h0000,
        pin_oe: 1'b0
    };

    pia_pkg::pia_state_t st_ff;
    pia_pkg::pia_state_t nxt_st;
    logic [14:0] ev_qual;
    logic [14:0] ev_capt;
    logic stat_rd;
    logic mask_wr;
    logic aux_wr;
    logic aux_rd;
    logic sticky_drop;
    logic pending;
    logic [15:0] stat_word;
    logic [15:0] aux_word;
    logic [15:0] rd_mux;

    assign stat_rd = mgmt_req.rd && (mgmt_req.addr == `PIA_REG_STAT);
    assign aux_rd = mgmt_req.rd && (mgmt_req.addr == `PIA_REG_AUX);
    assign mask_wr = mgmt_req.wr && (mgmt_req.addr == `PIA_REG_MASK);
    assign aux_wr = mgmt_req.wr && (mgmt_req.addr == `PIA_REG_AUX);
    assign sticky_drop = soft_reset && !sticky_reset_en;

    // ------------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------------
    always_comb begin
        ev_qual = event_pulse & `PIA_EV_VALID;
        if (!phy_stat.an_enable) begin
            ev_qual[`PIA_EV_SPEED] = 1'b0;
            ev_qual[`PIA_EV_DUPLEX] = 1'b0;
        end
        if (!(&phy_stat.adv_bits)) begin
            ev_qual[`PIA_EV_DOWNSHIFT] = 1'b0;
        end
        if (phy_stat.carrier_ext) begin
            ev_qual[`PIA_EV_RXERR] = 1'b0;
        end
    end

    // The pin enable bit takes no part in capture, only in driving the pin.
    assign ev_capt = ev_qual & st_ff.mask[14:0];

    assign pending = |st_ff.flags;

    always_comb begin
        stat_word = {1'b0, st_ff.flags};
        stat_word[`PIA_SUM_BIT] = pending;
    end

    // ------------------------------------------------------------------------
    // Auxiliary status word
    // ------------------------------------------------------------------------
    always_comb begin
        aux_word = 16'h0000;
        aux_word[`PIA_AUX_ANC] = phy_stat.an_complete;
        aux_word[`PIA_AUX_AN_DIS] = !phy_stat.an_enable;
        aux_word[`PIA_AUX_MDIX] = phy_stat.mdix_crossover;
        aux_word[`PIA_AUX_CD_SWAP] = phy_stat.cd_swap;
        aux_word[`PIA_AUX_POL_HI:`PIA_AUX_POL_LO] = phy_stat.pol_inv;
        aux_word[`PIA_AUX_TMO_MSB] = st_ff.tmo[1];
        aux_word[`PIA_AUX_TMO_LSB] = st_ff.tmo[0];
    end

    always_comb begin
        case (mgmt_req.addr)
            `PIA_REG_MASK: rd_mux = st_ff.mask;
            `PIA_REG_STAT: rd_mux = stat_word;
            `PIA_REG_AUX: rd_mux = aux_word;
            default: rd_mux = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // An event in the cycle of the clearing read is kept.
        if (stat_rd) begin
            nxt_st.flags = ev_capt;
        end else begin
            nxt_st.flags = st_ff.flags | ev_capt;
        end
        if (mask_wr) begin
            nxt_st.mask = mgmt_req.wdata & `PIA_MASK_WR;
        end
        if (aux_wr) begin
            nxt_st.tmo = {mgmt_req.wdata[`PIA_AUX_TMO_MSB], mgmt_req.wdata[`PIA_AUX_TMO_LSB]};
        end
        if (sticky_drop) begin
            nxt_st.mask = `PIA_MASK_RST;
            nxt_st.tmo = `PIA_TMO_RST;
        end
        if (mgmt_req.rd) begin
            nxt_st.rdata = rd_mux;
        end
        nxt_st.pin_oe = st_ff.mask[`PIA_PIN_EN_BIT] && pending;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // The pin is open drain and active low: it only ever pulls down.
    assign management_interrupt_pin_o = 1'b0;
    assign management_interrupt_pin_oe = st_ff.pin_oe;
    assign mgmt_rdata = st_ff.rdata;
    assign link_tmo_code = st_ff.tmo;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_stat_read;
        stat_rd && (ev_capt == 15'h0000);
    endsequence

    sequence s_flags_gone;
        (st_ff.flags == 15'h0000) ##1 !st_ff.pin_oe;
    endsequence

    property p_pin_needs_enable;
        management_interrupt_pin_oe |-> $past(st_ff.mask[`PIA_PIN_EN_BIT]);
    endproperty
    a_pin_needs_enable: assert property (p_pin_needs_enable)
        else $error("interrupt pin driven without master enable");

    property p_pin_follows;
        st_ff.mask[`PIA_PIN_EN_BIT] && pending |=> management_interrupt_pin_oe;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("interrupt pin failed to follow pending summary");

    property p_disable_keeps_flags;
        mask_wr && !mgmt_req.wdata[`PIA_PIN_EN_BIT] && !stat_rd
            |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags);
    endproperty
    a_disable_keeps_flags: assert property (p_disable_keeps_flags)
        else $error("clearing pin enable disturbed pending flags");

    property p_reserved_zero;
        !st_ff.mask[`PIA_RSVD_HI] && !st_ff.mask[`PIA_RSVD_LO]
            && !st_ff.flags[`PIA_RSVD_HI] && !st_ff.flags[`PIA_RSVD_LO];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mask or flag bit set");

    property p_sticky_keep;
        soft_reset && sticky_reset_en && !mask_wr && !aux_wr
            |=> st_ff.mask == $past(st_ff.mask) && st_ff.tmo == $past(st_ff.tmo);
    endproperty
    a_sticky_keep: assert property (p_sticky_keep)
        else $error("sticky bits lost on soft reset with retention");

    property p_soft_default;
        sticky_drop |=> st_ff.mask == `PIA_MASK_RST && st_ff.tmo == `PIA_TMO_RST;
    endproperty
    a_soft_default: assert property (p_soft_default)
        else $error("sticky bits not defaulted on soft reset");

    property p_read_clears;
        s_stat_read |=> s_flags_gone;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear flags");

    property p_read_value;
        stat_rd |=> mgmt_rdata == {$past(pending), $past(st_ff.flags)};
    endproperty
    a_read_value: assert property (p_read_value)
        else $error("status read returned wrong word");

    property p_latch_enabled;
        event_pulse[`PIA_EV_LINK] && st_ff.mask[`PIA_EV_LINK] |=> st_ff.flags[`PIA_EV_LINK];
    endproperty
    a_latch_enabled: assert property (p_latch_enabled)
        else $error("enabled event not latched");

    property p_latch_masked;
        !st_ff.flags[`PIA_EV_LINK] && !st_ff.mask[`PIA_EV_LINK] |=> !st_ff.flags[`PIA_EV_LINK];
    endproperty
    a_latch_masked: assert property (p_latch_masked)
        else $error("masked event latched");

    property p_speed_gate;
        stat_rd && !phy_stat.an_enable
            |=> !st_ff.flags[`PIA_EV_SPEED] && !st_ff.flags[`PIA_EV_DUPLEX];
    endproperty
    a_speed_gate: assert property (p_speed_gate)
        else $error("speed or duplex event without autonegotiation");

    property p_downshift_gate;
        stat_rd && !(&phy_stat.adv_bits) |=> !st_ff.flags[`PIA_EV_DOWNSHIFT];
    endproperty
    a_downshift_gate: assert property (p_downshift_gate)
        else $error("downshift event without full advertisement");

    property p_rxerr_gate;
        stat_rd && phy_stat.carrier_ext |=> !st_ff.flags[`PIA_EV_RXERR];
    endproperty
    a_rxerr_gate: assert property (p_rxerr_gate)
        else $error("receive error event during carrier extension");

    property p_aux_an;
        aux_rd |=> mgmt_rdata[`PIA_AUX_ANC] == $past(phy_stat.an_complete)
            && mgmt_rdata[`PIA_AUX_AN_DIS] == !$past(phy_stat.an_enable);
    endproperty
    a_aux_an: assert property (p_aux_an)
        else $error("aux autonegotiation bits wrong");

    property p_aux_pairs;
        aux_rd |=> mgmt_rdata[`PIA_AUX_POL_HI:`PIA_AUX_POL_LO] == $past(phy_stat.pol_inv)
            && mgmt_rdata[`PIA_AUX_MDIX] == $past(phy_stat.mdix_crossover)
            && mgmt_rdata[`PIA_AUX_CD_SWAP] == $past(phy_stat.cd_swap);
    endproperty
    a_aux_pairs: assert property (p_aux_pairs)
        else $error("aux pair status bits wrong");

    property p_tmo_write;
        aux_wr && !sticky_drop |=> link_tmo_code
            == {$past(mgmt_req.wdata[`PIA_AUX_TMO_MSB]), $past(mgmt_req.wdata[`PIA_AUX_TMO_LSB])};
    endproperty
    a_tmo_write: assert property (p_tmo_write)
        else $error("link timeout field not written");

    sequence s_link_event;
        event_pulse[`PIA_EV_LINK] && st_ff.mask[`PIA_EV_LINK] && st_ff.mask[`PIA_PIN_EN_BIT]
            && !mask_wr && !sticky_drop;
    endsequence

    property p_summary_read;
        stat_rd && (st_ff.flags != 15'h0000) |=> mgmt_rdata[`PIA_SUM_BIT];
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("status read lost the pending summary bit");

    property p_mask_write;
        mask_wr && !sticky_drop
            |=> st_ff.mask == ($past(mgmt_req.wdata) & `PIA_MASK_WR);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write did not land on writable bits");

    property p_pin_drops;
        !pending |=> !management_interrupt_pin_oe;
    endproperty
    a_pin_drops: assert property (p_pin_drops)
        else $error("interrupt pin driven with nothing pending");

    property p_event_to_pin;
        s_link_event |=> ##1 management_interrupt_pin_oe;
    endproperty
    a_event_to_pin: assert property (p_event_to_pin)
        else $error("enabled event did not reach the interrupt pin");

    property p_aux_tmo_read;
        aux_rd |=> mgmt_rdata[`PIA_AUX_TMO_MSB] == $past(st_ff.tmo[1])
            && mgmt_rdata[`PIA_AUX_TMO_LSB] == $past(st_ff.tmo[0]);
    endproperty
    a_aux_tmo_read: assert property (p_aux_tmo_read)
        else $error("aux timeout bits read back wrong");

    property p_tmo_stable;
        !aux_wr && !sticky_drop |=> $stable(st_ff.tmo);
    endproperty
    a_tmo_stable: assert property (p_tmo_stable)
        else $error("link timeout field changed with no write");

    property p_mask_stable;
        !mask_wr && !sticky_drop |=> $stable(st_ff.mask);
    endproperty
    a_mask_stable: assert property (p_mask_stable)
        else $error("mask changed with no write");

endmodule // pia_irq_aux

`default_nettype wire

// *** pia_smc_model.sv ***
// Station management controller model that drives the register port.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"

module pia_smc_model (
    input wire logic ref_clk,
    output var pia_pkg::pia_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata
);
    initial mgmt_req = '0;

    // Released address and data lines are inverted so stale values never look live.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        mgmt_req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        @(posedge ref_clk);
        mgmt_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        mgmt_req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: mgmt_req.wdata};
        @(posedge ref_clk);
        mgmt_req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~mgmt_req.wdata};
        #1 d = mgmt_rdata;
    endtask

    // Stale pending flags are flushed before the pin is enabled.
    task automatic enable_pin(input logic [15:0] m);
        logic [15:0] stale;
        rd(`PIA_REG_STAT, stale);
        wr(`PIA_REG_MASK, m | 16'h8000);
    endtask
endmodule // pia_smc_model
`default_nettype wire

// *** phy_interrupt_and_aux_status_tb.sv ***
// Self-checking testbench of the PHY interrupt and aux status block.
`timescale 1ns/100ps
`default_nettype none
`include "pia_cfg.svh"

module phy_interrupt_and_aux_status_tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    pia_pkg::pia_mgmt_req_t mgmt_req;
    logic [15:0] mgmt_rdata;
    logic [14:0] event_pulse = '0;
    pia_pkg::pia_phy_stat_t phy_stat = '0;
    logic soft_reset = 1'b0;
    logic sticky_reset_en = 1'b1;
    logic pin_o;
    logic pin_oe;
    logic [1:0] link_tmo_code;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] d;

    always #2.5 ref_clk = ~ref_clk;

    pia_irq_aux dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .event_pulse(event_pulse), .phy_stat(phy_stat), .soft_reset(soft_reset),
        .sticky_reset_en(sticky_reset_en), .management_interrupt_pin_o(pin_o),
        .management_interrupt_pin_oe(pin_oe), .link_tmo_code(link_tmo_code)
    );

    pia_smc_model smc (.ref_clk(ref_clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata));

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pulse(input logic [14:0] v);
        @(posedge ref_clk);
        event_pulse <= v;
        @(posedge ref_clk);
        event_pulse <= '0;
        #1;
    endtask

    task automatic t_reset();
        smc.rd(`PIA_REG_MASK, d);
        chk(d, 16'h0000);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'h0000);
        smc.rd(`PIA_REG_AUX, d);
        chk(d, 16'h4004);
        chk({14'h0, link_tmo_code}, 16'h0001);
        chk({15'h0, pin_oe}, 16'h0000);
        smc.rd(5'h03, d);
        chk(d, 16'h0000);
    endtask

    task automatic t_mask();
        smc.wr(`PIA_REG_MASK, 16'hffff);
        smc.wr(`PIA_REG_STAT, 16'hffff);
        smc.rd(`PIA_REG_MASK, d);
        chk(d, 16'hff6f);
        smc.wr(`PIA_REG_MASK, 16'h7f6f);
    endtask

    task automatic t_events();
        @(posedge ref_clk);
        phy_stat <= '{an_enable: 1'b1, adv_bits: 4'hf, default: 1'b0};
        for (int k = 0; k < 15; k++) begin
            if (`PIA_EV_VALID >> k & 1) begin
                pulse(15'h1 << k);
                smc.rd(`PIA_REG_STAT, d);
                chk(d, 16'h8000 | 16'h1 << k);
                smc.rd(`PIA_REG_STAT, d);
                chk(d, 16'h0000);
                chk({15'h0, pin_oe}, 16'h0000);
            end
        end
        pulse(15'h0090);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'h0000);
    endtask

    task automatic t_qual();
        @(posedge ref_clk);
        phy_stat <= '{adv_bits: 4'h7, carrier_ext: 1'b1, default: 1'b0};
        pulse(15'h5005);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'h0000);
        smc.wr(`PIA_REG_MASK, 16'h5f6f);
        pulse(15'h2008);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'h8008);
    endtask

    task automatic t_pin();
        pulse(15'h0020);
        smc.enable_pin(16'h7f6f);
        @(posedge ref_clk);
        #1 chk({15'h0, pin_oe}, 16'h0000);
        pulse(15'h2000);
        @(posedge ref_clk);
        #1 chk({15'h0, pin_oe}, 16'h0001);
        chk({15'h0, pin_o}, 16'h0000);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'ha000);
        @(posedge ref_clk);
        #1 chk({15'h0, pin_oe}, 16'h0000);
        smc.wr(`PIA_REG_MASK, 16'h7f6f);
        pulse(15'h2000);
        repeat (3) @(posedge ref_clk);
        #1 chk({15'h0, pin_oe}, 16'h0000);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'ha000);
    endtask

    task automatic t_aux();
        @(posedge ref_clk);
        phy_stat <= '{an_complete: 1'b1, mdix_crossover: 1'b1, pol_inv: 4'ha, default: 1'b0};
        smc.rd(`PIA_REG_AUX, d);
        chk(d, 16'hea04);
        @(posedge ref_clk);
        phy_stat <= '{an_enable: 1'b1, cd_swap: 1'b1, pol_inv: 4'h5, default: 1'b0};
        smc.wr(`PIA_REG_AUX, 16'hffff);
        smc.rd(`PIA_REG_AUX, d);
        chk(d, 16'h1584);
        chk({14'h0, link_tmo_code}, 16'h0003);
        smc.wr(`PIA_REG_AUX, 16'h0080);
        #1 chk({14'h0, link_tmo_code}, 16'h0002);
    endtask

    task automatic t_soft();
        pulse(15'h0400);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        smc.rd(`PIA_REG_MASK, d);
        chk(d, 16'h7f6f);
        chk({14'h0, link_tmo_code}, 16'h0002);
        @(posedge ref_clk);
        sticky_reset_en <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        smc.rd(`PIA_REG_MASK, d);
        chk(d, 16'h0000);
        chk({14'h0, link_tmo_code}, 16'h0001);
        smc.rd(`PIA_REG_STAT, d);
        chk(d, 16'h8400);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_mask();
        t_events();
        t_qual();
        t_pin();
        t_aux();
        t_soft();
        summarize();
    end
endmodule // phy_interrupt_and_aux_status_tb
`default_nettype wire
